// file: core/mesc_fence_xform.v
`timescale 1ns/1ps
module mesc_fence_xform (
   input  wire       ref_clk_i,
   input  wire       sys_rst_i,
   input  wire       widen_i,
   input  wire [7:0] fence_bits_i,
   input  wire       amo_io_i,
   input  wire       amo_aq_i,
   input  wire       amo_rl_i,
   output reg  [7:0] fence_eff_o,
   output reg        amo_mem_order_o
);
   // fence bits: 7 pi, 6 po, 5 pr, 4 pw, 3 si, 2 so, 1 sr, 0 sw
   wire [7:0] nxt_eff;
   assign nxt_eff[7] = fence_bits_i[7];
   assign nxt_eff[6] = fence_bits_i[6];
   assign nxt_eff[5] = fence_bits_i[5] | (widen_i & fence_bits_i[7]);
   assign nxt_eff[4] = fence_bits_i[4] | (widen_i & fence_bits_i[6]);
   assign nxt_eff[3] = fence_bits_i[3];
   assign nxt_eff[2] = fence_bits_i[2];
   assign nxt_eff[1] = fence_bits_i[1] | (widen_i & fence_bits_i[3]);
   assign nxt_eff[0] = fence_bits_i[0] | (widen_i & fence_bits_i[2]);

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         fence_eff_o     <= 8'h00;
         amo_mem_order_o <= 1'b0;
      end else begin
         fence_eff_o     <= nxt_eff;
         amo_mem_order_o <= widen_i & amo_io_i & (amo_aq_i | amo_rl_i);
      end
   end
endmodule // mesc_fence_xform

// file: core/mesc_lp_track.v
`timescale 1ns/1ps
module mesc_lp_track (
   input  wire ref_clk_i,
   input  wire sys_rst_i,
   input  wire lp_en_i,
   input  wire indirect_jump_i,
   input  wire landing_pad_instr_exec_i,
   output reg  elp_expected_o,
   output reg  landing_pad_instr_nop_o
);
   // 0 is no_landing_expected; a disabled mode never leaves it
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         elp_expected_o <= 1'b0;
         landing_pad_instr_nop_o     <= 1'b1;
      end else begin
         landing_pad_instr_nop_o <= ~lp_en_i;
         if (!lp_en_i)
            elp_expected_o <= 1'b0;
         else if (indirect_jump_i)
            elp_expected_o <= 1'b1;
         else if (landing_pad_instr_exec_i)
            elp_expected_o <= 1'b0;
      end
   end
endmodule // mesc_lp_track

// file: core/mesc_map.vh
// Operation
// - read-only pointer to platform configuration data
// - pointer low three bits always read zero
// - pointer always present; zero means none
// - 64-bit environment register with fixed field layout
// - fence device bits also order memory below machine
// - ordered device atomics also order memory below machine
// - fence-memory bit hardwired zero without translation
// - page memory types gated; guest copy follows
// - translation fence suffices after page type change
// - hardware access/dirty update gated; guest copy follows
// - counter delegation gated; zero when unsupported
// - supervisor landing pad enable controls expected state
// - shadow stack off turns instructions to no-ops below machine
// - shadow stack off zeros lower enable copies
// - double trap off zeros double trap bits
// - environment high alias only at width 32
// - no user mode means no environment registers
// - optional 64-bit security register with fixed fields
// - machine landing pad enable controls expected state
// - security high alias only at width 32
`ifndef MESC_MAP_VH
`define MESC_MAP_VH
`define MESC_A_PTR      12'hf15
`define MESC_A_ENV      12'h30a
`define MESC_A_ENVH     12'h31a
`define MESC_A_SEC      12'h747
`define MESC_A_SECH     12'h757
`define MESC_PTR_ZBITS  3
`define MESC_RST64      64'h0000_0000_0000_0000
`define MESC_B_SUPERVISOR_TIMER_COMPARE_ENABLE     63
`define MESC_B_PAGE_MEMORY_TYPE_ENABLE    62
`define MESC_B_HW_ACCESS_DIRTY_UPDATE_ENABLE     61
`define MESC_B_CDE      60
`define MESC_B_DTE      59
`define MESC_B_PMM_HI   33
`define MESC_B_PMM_LO   32
`define MESC_B_CACHE_ZERO_ENABLE     7
`define MESC_B_CACHE_CLEAN_FLUSH_ENABLE    6
`define MESC_B_CACHE_INVALIDATE_ENABLE_HI  5
`define MESC_B_CACHE_INVALIDATE_ENABLE_LO  4
`define MESC_B_SSE      3
`define MESC_B_LPE      2
`define MESC_B_FENCE_IO_IMPLIES_MEMORY     0
`define MESC_B_MACHINE_LANDING_PAD_ENABLE     10
`define MESC_B_SUPERVISOR_SEED_ACCESS    9
`define MESC_B_USER_SEED_ACCESS    8
`define MESC_B_RLB      2
`define MESC_B_WHITELIST_POLICY     1
`define MESC_B_MML      0
`define MESC_ENV_BASE   64'h0000_0003_0000_00fc
`define MESC_SEC_MASK   64'h0000_0000_0000_0707
`define MESC_PRV_U      2'h0
`define MESC_PRV_S      2'h1
`define MESC_PRV_M      2'h3
`endif

// file: core/mesc_top.v
`timescale 1ns/1ps
`include "mesc_map.vh"
module mesc_top #(
   parameter [63:0] CFG_PTR    = 64'h0000_0000_0000_0000,
   parameter        HAS_U      = 1,
   parameter        HAS_S      = 1,
   parameter        SATP_BARE  = 0,
   parameter        HAS_STC    = 1,
   parameter        HAS_PBMT   = 1,
   parameter        HAS_ADU    = 1,
   parameter        HAS_CDEL   = 1,
   parameter        HAS_DTRAP  = 1,
   parameter        HAS_PMASK  = 1,
   parameter        HAS_CBO    = 1,
   parameter        HAS_CFI    = 1,
   parameter        HAS_SEC    = 1
) (
   input  wire        ref_clk_i,
   input  wire        sys_rst_i,
   input  wire        xlen32_i,
   input  wire [1:0]  priv_i,
   input  wire        csr_valid_i,
   input  wire        csr_write_i,
   input  wire [11:0] csr_addr_i,
   input  wire [63:0] csr_wdata_i,
   output reg         csr_ack_o,
   output reg         csr_err_o,
   output reg  [63:0] csr_rdata_o,
   input  wire [7:0]  fence_bits_i,
   input  wire        amo_io_i,
   input  wire        amo_aq_i,
   input  wire        amo_rl_i,
   output wire [7:0]  fence_eff_o,
   output wire        amo_mem_order_o,
   input  wire        indirect_jump_i,
   input  wire        landing_pad_instr_exec_i,
   output wire        elp_expected_o,
   output wire        landing_pad_instr_nop_o,
   input  wire        page_memory_type_enable_chg_i,
   output reg         tlb_resync_o,
   output reg  [63:0] env_cfg_o,
   output reg  [63:0] sec_cfg_o,
   output reg         hyp_page_memory_type_enable_allow_o,
   output reg         hyp_hw_access_dirty_update_enable_allow_o,
   output reg         hyp_dte_allow_o,
   output reg         sdt_allow_o,
   output reg         lower_sse_allow_o,
   output reg         ss_as_mop_o,
   output reg         pte_010_rsvd_o,
   output reg         ssamoswap_ill_o,
   output reg         cnt_deleg_on_o,
   output reg         adu_hw_update_o
);
   reg  [63:0] env_ff;
   reg  [63:0] sec_ff;
   reg  [63:0] nxt_env;
   reg  [63:0] nxt_sec;
   reg  [63:0] nxt_rdata;
   reg         nxt_err;
   wire [63:0] env_mask;
   wire [63:0] sec_mask;
   wire [63:0] ptr_val;
   wire        fence_io_implies_memory_ok;
   wire        below_m;
   wire        lp_en;
   wire        hit_ptr;
   wire        hit_env;
   wire        hit_envh;
   wire        hit_sec;
   wire        hit_sech;
   wire        wr;

   // three low bits forced to zero for 8-byte alignment
   assign ptr_val = {CFG_PTR[63:`MESC_PTR_ZBITS],
                     {`MESC_PTR_ZBITS{1'b0}}};

   assign fence_io_implies_memory_ok = (HAS_S != 0) && (SATP_BARE == 0);

   // writable fields; everything else reads zero
   assign env_mask[63] = (HAS_STC != 0);
   assign env_mask[62] = (HAS_PBMT != 0);
   assign env_mask[61] = (HAS_ADU != 0);
   assign env_mask[60] = (HAS_CDEL != 0);
   assign env_mask[59] = (HAS_DTRAP != 0);
   assign env_mask[58:34] = 25'h0000000;
   assign env_mask[33:32] = {2{HAS_PMASK != 0}};
   assign env_mask[31:8] = 24'h000000;
   assign env_mask[7:4] = {4{HAS_CBO != 0}};
   assign env_mask[3:2] = {2{HAS_CFI != 0}};
   assign env_mask[1] = 1'b0;
   assign env_mask[0] = fence_io_implies_memory_ok;

   assign sec_mask = (HAS_SEC != 0) ? `MESC_SEC_MASK
                                    : `MESC_RST64;

   assign hit_ptr  = (csr_addr_i == `MESC_A_PTR);
   assign hit_env  = (csr_addr_i == `MESC_A_ENV) && (HAS_U != 0);
   assign hit_envh = (csr_addr_i == `MESC_A_ENVH) && (HAS_U != 0)
                     && xlen32_i;
   assign hit_sec  = (csr_addr_i == `MESC_A_SEC) && (HAS_SEC != 0);
   assign hit_sech = (csr_addr_i == `MESC_A_SECH) && (HAS_SEC != 0)
                     && xlen32_i;
   assign wr = csr_valid_i & csr_write_i;

   // read data and access error
   always @* begin
      nxt_rdata = `MESC_RST64;
      nxt_err   = 1'b0;
      if (hit_ptr)
         nxt_rdata = ptr_val;
      else if (hit_env)
         nxt_rdata = env_ff;
      else if (hit_envh)
         nxt_rdata = {32'h00000000, env_ff[63:32]};
      else if (hit_sec)
         nxt_rdata = sec_ff;
      else if (hit_sech)
         nxt_rdata = {32'h00000000, sec_ff[63:32]};
      else
         nxt_err = 1'b1;
      if (hit_ptr && csr_write_i)
         nxt_err = 1'b1;
      if (xlen32_i)
         nxt_rdata = {32'h00000000, nxt_rdata[31:0]};
   end

   // write merge: low word only at width 32, high via alias
   always @* begin
      nxt_env = env_ff;
      nxt_sec = sec_ff;
      if (wr && hit_env) begin
         if (xlen32_i)
            nxt_env = {env_ff[63:32], csr_wdata_i[31:0]};
         else
            nxt_env = csr_wdata_i;
      end
      if (wr && hit_envh)
         nxt_env = {csr_wdata_i[31:0], env_ff[31:0]};
      if (wr && hit_sec) begin
         if (xlen32_i)
            nxt_sec = {sec_ff[63:32], csr_wdata_i[31:0]};
         else
            nxt_sec = csr_wdata_i;
      end
      if (wr && hit_sech)
         nxt_sec = {csr_wdata_i[31:0], sec_ff[31:0]};
      nxt_env = nxt_env & env_mask;
      nxt_sec = nxt_sec & sec_mask;
   end

   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         env_ff      <= `MESC_RST64;
         sec_ff      <= `MESC_RST64;
         csr_ack_o   <= 1'b0;
         csr_err_o   <= 1'b0;
         csr_rdata_o <= `MESC_RST64;
      end else begin
         env_ff    <= nxt_env;
         sec_ff    <= nxt_sec;
         csr_ack_o <= csr_valid_i;
         csr_err_o <= csr_valid_i & nxt_err;
         if (csr_valid_i)
            csr_rdata_o <= nxt_err ? `MESC_RST64 : nxt_rdata;
      end
   end

   assign below_m = (priv_i != `MESC_PRV_M);

   // landing pad enable for the current mode
   assign lp_en = below_m ?
                  env_ff[`MESC_B_LPE] & ((HAS_S == 0) ||
                     (priv_i == `MESC_PRV_S))
                  : sec_ff[`MESC_B_MACHINE_LANDING_PAD_ENABLE];

   // effects seen by the rest of the hart
   always @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         env_cfg_o         <= `MESC_RST64;
         sec_cfg_o         <= `MESC_RST64;
         hyp_page_memory_type_enable_allow_o <= 1'b0;
         hyp_hw_access_dirty_update_enable_allow_o  <= 1'b0;
         hyp_dte_allow_o   <= 1'b0;
         sdt_allow_o       <= 1'b0;
         lower_sse_allow_o <= 1'b0;
         ss_as_mop_o       <= 1'b1;
         pte_010_rsvd_o    <= 1'b1;
         ssamoswap_ill_o   <= 1'b1;
         cnt_deleg_on_o    <= 1'b0;
         adu_hw_update_o   <= 1'b0;
         tlb_resync_o      <= 1'b0;
      end else begin
         env_cfg_o         <= env_ff;
         sec_cfg_o         <= sec_ff;
         hyp_page_memory_type_enable_allow_o <= env_ff[`MESC_B_PAGE_MEMORY_TYPE_ENABLE];
         hyp_hw_access_dirty_update_enable_allow_o  <= env_ff[`MESC_B_HW_ACCESS_DIRTY_UPDATE_ENABLE];
         adu_hw_update_o   <= env_ff[`MESC_B_HW_ACCESS_DIRTY_UPDATE_ENABLE];
         hyp_dte_allow_o   <= env_ff[`MESC_B_DTE];
         sdt_allow_o       <= env_ff[`MESC_B_DTE];
         cnt_deleg_on_o    <= env_ff[`MESC_B_CDE];
         lower_sse_allow_o <= env_ff[`MESC_B_SSE];
         ss_as_mop_o     <= below_m & ~env_ff[`MESC_B_SSE];
         pte_010_rsvd_o  <= ~env_ff[`MESC_B_SSE];
         ssamoswap_ill_o <= below_m & ~env_ff[`MESC_B_SSE];
         // a page type change asks for a full translation fence
         tlb_resync_o <= page_memory_type_enable_chg_i |
                         (wr && (hit_env || hit_envh) &&
                          (nxt_env[`MESC_B_PAGE_MEMORY_TYPE_ENABLE] !=
                           env_ff[`MESC_B_PAGE_MEMORY_TYPE_ENABLE]));
      end
   end

   mesc_fence_xform u_fence (
      .ref_clk_i       (ref_clk_i),
      .sys_rst_i       (sys_rst_i),
      .widen_i         (below_m & env_ff[`MESC_B_FENCE_IO_IMPLIES_MEMORY]),
      .fence_bits_i    (fence_bits_i),
      .amo_io_i        (amo_io_i),
      .amo_aq_i        (amo_aq_i),
      .amo_rl_i        (amo_rl_i),
      .fence_eff_o     (fence_eff_o),
      .amo_mem_order_o (amo_mem_order_o)
   );

   mesc_lp_track u_lp (
      .ref_clk_i       (ref_clk_i),
      .sys_rst_i       (sys_rst_i),
      .lp_en_i         (lp_en),
      .indirect_jump_i (indirect_jump_i),
      .landing_pad_instr_exec_i     (landing_pad_instr_exec_i),
      .elp_expected_o  (elp_expected_o),
      .landing_pad_instr_nop_o      (landing_pad_instr_nop_o)
   );
endmodule // mesc_top

// file: sim/mesc_top_assertions.sv
`timescale 1ns/1ps
module mesc_top_checker (
   input wire        ref_clk_i,
   input wire        sys_rst_i,
   input wire        xlen32_i,
   input wire [1:0]  priv_i,
   input wire        csr_valid_i,
   input wire        csr_write_i,
   input wire [11:0] csr_addr_i,
   input wire        csr_err_o,
   input wire [63:0] csr_rdata_o,
   input wire [7:0]  fence_bits_i,
   input wire        amo_io_i,
   input wire        amo_aq_i,
   input wire        amo_rl_i,
   input wire [7:0]  fence_eff_o,
   input wire        amo_mem_order_o,
   input wire [63:0] env_cfg_o,
   input wire [63:0] sec_cfg_o,
   input wire        lower_sse_allow_o,
   input wire        pte_010_rsvd_o,
   input wire        elp_expected_o,
   input wire        landing_pad_instr_nop_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire rd  = csr_valid_i && !csr_write_i;
   wire amo = amo_io_i && (amo_aq_i || amo_rl_i);
   // env copy one cycle later shows the bit the fence was judged by
   sequence wid;
      priv_i != 2'h3 ##1 env_cfg_o[0];
   endsequence
   ptr_write_err_a: assert property (
      csr_valid_i && csr_write_i && csr_addr_i == 12'hf15 |=> csr_err_o)
      else $error("pointer write not refused");
   ptr_align_a: assert property (
      rd && csr_addr_i == 12'hf15 |=> csr_rdata_o[2:0] == 3'h0)
      else $error("pointer low bits not zero");
   alias_absent_a: assert property (
      csr_valid_i && !xlen32_i && csr_addr_i[11:4] inside {8'h31, 8'h75}
      && csr_addr_i[3:0] inside {4'ha, 4'h7} |=> csr_err_o)
      else $error("high alias answered at width 64");
   env_rsvd_a: assert property (
      (env_cfg_o & ~64'hf800_0003_0000_00fd) == 64'h0)
      else $error("reserved env bit set");
   sec_rsvd_a: assert property (
      (sec_cfg_o & ~64'h0707) == 64'h0) else $error("reserved sec bit set");
   fence_widen_a: assert property (
      wid |-> fence_eff_o == ($past(fence_bits_i)
      | (($past(fence_bits_i) >> 2) & 8'h33))) else $error("fence not widened");
   amo_order_a: assert property (
      wid |-> amo_mem_order_o == $past(amo)) else $error("amo order wrong");
   fence_plain_a: assert property (
      priv_i != 2'h3 ##1 !env_cfg_o[0] |->
      fence_eff_o == $past(fence_bits_i) && !amo_mem_order_o)
      else $error("fence widened with bit clear");
   fence_machine_a: assert property (
      priv_i == 2'h3 |=> fence_eff_o == $past(fence_bits_i) && !amo_mem_order_o)
      else $error("fence changed in machine mode");
   sse_rsvd_a: assert property (
      pte_010_rsvd_o == !env_cfg_o[3]) else $error("pte 010 reserve wrong");
   sse_lower_a: assert property (
      lower_sse_allow_o == env_cfg_o[3]) else $error("lower sse allow wrong");
   lp_off_a: assert property (
      landing_pad_instr_nop_o |-> !elp_expected_o) else $error("landing state left idle");
   cover property (wid);
   cover property (rd && csr_addr_i == 12'hf15);
   cover property (csr_valid_i && xlen32_i && csr_addr_i == 12'h31a);
endmodule // mesc_top_checker

// file: sim/mesc_top_tb.sv
`timescale 1ns/1ps
`include "mesc_map.vh"
module mesc_top_tb;
   localparam [63:0] PTR  = 64'h0000_0000_8000_123f;
   localparam [63:0] ENVM = 64'hf800_0003_0000_00fd;
   reg         ref_clk_i = 1'b0;
   reg         sys_rst_i = 1'b1;
   reg         xlen32_i = 1'b0;
   reg  [1:0]  priv_i = 2'h3;
   reg         csr_valid_i = 1'b0;
   reg         csr_write_i = 1'b0;
   reg  [11:0] csr_addr_i = 12'h0;
   reg  [63:0] csr_wdata_i = 64'h0;
   reg  [7:0]  fence_bits_i = 8'h0;
   reg         amo_io_i = 1'b0, amo_aq_i = 1'b0, amo_rl_i = 1'b0;
   reg         indirect_jump_i = 1'b0, landing_pad_instr_exec_i = 1'b0;
   reg         page_memory_type_enable_chg_i = 1'b0;
   wire [63:0] csr_rdata_o, env_cfg_o, sec_cfg_o;
   wire [7:0]  fence_eff_o;
   wire        csr_ack_o, csr_err_o, amo_mem_order_o, elp_expected_o;
   wire        landing_pad_instr_nop_o, tlb_resync_o, hyp_page_memory_type_enable_allow_o, sdt_allow_o;
   wire        hyp_hw_access_dirty_update_enable_allow_o, hyp_dte_allow_o, lower_sse_allow_o;
   wire        ss_as_mop_o, pte_010_rsvd_o, ssamoswap_ill_o;
   wire        cnt_deleg_on_o, adu_hw_update_o;
   integer     fails = 0, n_checks = 0, seed = 32'hce85, i;
   reg  [65:0] expq[$];
   reg  [65:0] q;
   reg  [63:0] d;
   reg  [31:0] r;
   mesc_top #(.CFG_PTR(PTR)) u_mesc_top (
      .ref_clk_i         (ref_clk_i),
      .sys_rst_i         (sys_rst_i),
      .xlen32_i          (xlen32_i),
      .priv_i            (priv_i),
      .csr_valid_i       (csr_valid_i),
      .csr_write_i       (csr_write_i),
      .csr_addr_i        (csr_addr_i),
      .csr_wdata_i       (csr_wdata_i),
      .csr_ack_o         (csr_ack_o),
      .csr_err_o         (csr_err_o),
      .csr_rdata_o       (csr_rdata_o),
      .fence_bits_i      (fence_bits_i),
      .amo_io_i          (amo_io_i),
      .amo_aq_i          (amo_aq_i),
      .amo_rl_i          (amo_rl_i),
      .fence_eff_o       (fence_eff_o),
      .amo_mem_order_o   (amo_mem_order_o),
      .indirect_jump_i   (indirect_jump_i),
      .landing_pad_instr_exec_i       (landing_pad_instr_exec_i),
      .elp_expected_o    (elp_expected_o),
      .landing_pad_instr_nop_o        (landing_pad_instr_nop_o),
      .page_memory_type_enable_chg_i       (page_memory_type_enable_chg_i),
      .tlb_resync_o      (tlb_resync_o),
      .env_cfg_o         (env_cfg_o),
      .sec_cfg_o         (sec_cfg_o),
      .hyp_page_memory_type_enable_allow_o (hyp_page_memory_type_enable_allow_o),
      .hyp_hw_access_dirty_update_enable_allow_o  (hyp_hw_access_dirty_update_enable_allow_o),
      .hyp_dte_allow_o   (hyp_dte_allow_o),
      .sdt_allow_o       (sdt_allow_o),
      .lower_sse_allow_o (lower_sse_allow_o),
      .ss_as_mop_o       (ss_as_mop_o),
      .pte_010_rsvd_o    (pte_010_rsvd_o),
      .ssamoswap_ill_o   (ssamoswap_ill_o),
      .cnt_deleg_on_o    (cnt_deleg_on_o),
      .adu_hw_update_o   (adu_hw_update_o)
   );
   always #10 ref_clk_i = ~ref_clk_i;
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task cmp(input string nm, input [63:0] e, input [63:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
   endtask
   // one access: request held through the taking edge, answer noted
   task acc(input w, input [11:0] a, input [63:0] wd, input e,
            input [63:0] rd);
      csr_valid_i = 1'b1;
      csr_write_i = w;
      csr_addr_i = a;
      csr_wdata_i = wd;
      expq.push_back({!w, e, rd});
      @(negedge ref_clk_i);
   endtask
   task rel;
      csr_valid_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
   endtask
   always @(negedge ref_clk_i)
      if (csr_ack_o === 1'b1) begin
         q = (expq.size() > 0) ? expq.pop_front() : {2'b11, 64'hdead};
         cmp("err", q[64], csr_err_o);
         if (q[65]) cmp("rdata", q[63:0], csr_rdata_o);
      end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      fails = fails + 1;
      $display("[ERR] watchdog exp done got timeout");
      conclude;
   end
   initial begin
      repeat (2) @(negedge ref_clk_i);
      sys_rst_i = 1'b0;
      cmp("reset", 3'h7, {landing_pad_instr_nop_o, pte_010_rsvd_o, ss_as_mop_o});
      acc(0, `MESC_A_PTR, 0, 0, PTR & ~64'h7);
      acc(1, `MESC_A_PTR, 64'h0, 1, 0);
      acc(0, `MESC_A_PTR, 0, 0, PTR & ~64'h7);
      acc(0, 12'h123, 0, 1, 0);
      acc(0, `MESC_A_ENVH, 0, 1, 0);
      acc(0, `MESC_A_SECH, 0, 1, 0);
      rel;
      $display("test pointer done");
      priv_i = 2'h1;
      acc(1, `MESC_A_ENV, {64{1'b1}}, 0, 0);
      cmp("resync", 1'b1, tlb_resync_o);
      acc(0, `MESC_A_ENV, 0, 0, ENVM);
      cmp("resync idle", 1'b0, tlb_resync_o);
      rel;
      cmp("copies", 9'h1fc, {hyp_page_memory_type_enable_allow_o, hyp_hw_access_dirty_update_enable_allow_o,
          hyp_dte_allow_o, sdt_allow_o, lower_sse_allow_o, cnt_deleg_on_o,
          adu_hw_update_o, landing_pad_instr_nop_o, ss_as_mop_o});
      acc(1, `MESC_A_ENV, 0, 0, 0);
      cmp("resync clear", 1'b1, tlb_resync_o);
      indirect_jump_i = 1'b1;
      rel;
      cmp("off", 6'h5, {hyp_page_memory_type_enable_allow_o, cnt_deleg_on_o, sdt_allow_o,
          landing_pad_instr_nop_o, elp_expected_o, ssamoswap_ill_o});
      priv_i = 2'h3;
      acc(1, `MESC_A_SEC, {64{1'b1}}, 0, 0);
      acc(0, `MESC_A_SEC, 0, 0, 64'h0707);
      rel;
      cmp("machine_landing_pad_enable on", 2'h1, {landing_pad_instr_nop_o, elp_expected_o});
      acc(1, `MESC_A_SEC, 0, 0, 0);
      rel;
      cmp("machine_landing_pad_enable off", 2'h2, {landing_pad_instr_nop_o, elp_expected_o});
      $display("test fields done");
      xlen32_i = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         d = {$random(seed), $random(seed)};
         acc(1, `MESC_A_ENV, d, 0, 0);
         acc(1, `MESC_A_ENVH, d, 0, 0);
         acc(0, `MESC_A_ENV, 0, 0, d[31:0] & ENVM[31:0]);
         acc(0, `MESC_A_ENVH, 0, 0, d[31:0] & ENVM[63:32]);
         acc(1, `MESC_A_SECH, d, 0, 0);
         acc(0, `MESC_A_SECH, 0, 0, 0);
      end
      rel;
      xlen32_i = 1'b0;
      $display("test alias done");
      acc(1, `MESC_A_ENV, 64'h1, 0, 0);
      rel;
      for (i = 0; i < 300; i = i + 1) begin
         r = $random(seed);
         priv_i = r[1] ? 2'h3 : {1'b0, r[0]};
         fence_bits_i = r[9:2];
         {amo_io_i, amo_aq_i, amo_rl_i} = r[12:10];
         {indirect_jump_i, landing_pad_instr_exec_i, page_memory_type_enable_chg_i} = r[15:13];
         // fence bit is set until the write in the middle of the run
         d[8:0] = {(priv_i != 2'h3) & amo_io_i & (amo_aq_i | amo_rl_i),
                   fence_bits_i | ((priv_i != 2'h3) ?
                   ((fence_bits_i >> 2) & 8'h33) : 8'h00)};
         if (i == 150) begin
            acc(1, `MESC_A_ENV, {r, r}, 0, 0);
            csr_valid_i = 1'b0;
         end
         @(negedge ref_clk_i);
         if (i < 150)
            cmp("fence", d[8:0], {amo_mem_order_o, fence_eff_o});
      end
      rel;
      $display("test fence done");
      conclude;
   end
endmodule // mesc_top_tb
bind mesc_top mesc_top_checker u_mesc_top_checker (
   .ref_clk_i         (ref_clk_i),
   .sys_rst_i         (sys_rst_i),
   .xlen32_i          (xlen32_i),
   .priv_i            (priv_i),
   .csr_valid_i       (csr_valid_i),
   .csr_write_i       (csr_write_i),
   .csr_addr_i        (csr_addr_i),
   .csr_err_o         (csr_err_o),
   .csr_rdata_o       (csr_rdata_o),
   .fence_bits_i      (fence_bits_i),
   .amo_io_i          (amo_io_i),
   .amo_aq_i          (amo_aq_i),
   .amo_rl_i          (amo_rl_i),
   .fence_eff_o       (fence_eff_o),
   .amo_mem_order_o   (amo_mem_order_o),
   .env_cfg_o         (env_cfg_o),
   .sec_cfg_o         (sec_cfg_o),
   .lower_sse_allow_o (lower_sse_allow_o),
   .pte_010_rsvd_o    (pte_010_rsvd_o),
   .elp_expected_o    (elp_expected_o),
   .landing_pad_instr_nop_o        (landing_pad_instr_nop_o)
);
